//--- hdl/aal_pkg.sv
package aal_pkg;

   // datapath widths
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int BUS_W = 32;
   localparam int ADDR_W = 6;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INSTR = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_DST = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_SRC = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_PSW = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_DECODE = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h1C;

   // reset values
   localparam logic [15:0] PSW_RST = 16'h0000;
   localparam logic [15:0] OPND_RST = 16'h0000;
   localparam logic [1:0] CTRL_RST = 2'h0;

   // status word flag positions
   localparam int FLAG_N = 0;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 2;
   localparam int FLAG_Z = 3;
   localparam int FLAG_E = 4;

   // control register fields
   localparam int CTRL_DEST_PSW = 0;
   localparam int CTRL_PSW_HI = 1;

   // most negative values
   localparam logic [15:0] WORD_MIN_NEG = 16'h8000;
   localparam logic [7:0] BYTE_MIN_NEG = 8'h80;

   // opcode groups (upper nibble) and highest legal low nibble
   localparam logic [3:0] GRP_ADD = 4'h0;
   localparam logic [3:0] GRP_WORD_SUM_WITH_CARRY_OP = 4'h1;
   localparam logic [3:0] GRP_AND = 4'h6;
   localparam logic [3:0] FORM_NIB_MAX = 4'h9;

   // instruction lengths in bytes
   localparam logic [2:0] LEN_SHORT = 3'h2;
   localparam logic [2:0] LEN_LONG = 3'h4;

   typedef enum logic [1:0] {
      AAL_OP_ADD = 2'b00,
      AAL_OP_WORD_SUM_WITH_CARRY_OP = 2'b01,
      AAL_OP_AND = 2'b10
   } aal_op_type;

   // low nibble of opcode, bit 0 dropped
   typedef enum logic [2:0] {
      AAL_FORM_RR = 3'b000,
      AAL_FORM_REG_MEM = 3'b001,
      AAL_FORM_MEM_REG = 3'b010,
      AAL_FORM_IMM = 3'b011,
      AAL_FORM_SHORT = 3'b100
   } aal_form_type;

   // upper two bits of the short-form nibble
   typedef enum logic [1:0] {
      AAL_SHORT_IMM3 = 2'b00,
      AAL_SHORT_IMM3_B = 2'b01,
      AAL_SHORT_IND = 2'b10,
      AAL_SHORT_POSTINC = 2'b11
   } aal_short_type;

   typedef struct packed {
      logic [2:0] imm3;
      logic [2:0] length;
      aal_short_type short_mode;
      aal_form_type form;
      aal_op_type op;
      logic byte_op;
      logic valid;
   } aal_decode_type;

   typedef struct packed {
      logic e;
      logic z;
      logic v;
      logic c;
      logic n;
   } aal_flags_type;

   typedef enum logic [1:0] {
      AAL_BUS_IDLE = 2'b00,
      AAL_BUS_ACK = 2'b01
   } aal_bus_type;

endpackage

//--- hdl/aal_decode.sv
`timescale 1ns/10ps
module aal_decode (
   // instruction bytes
   input wire logic [7:0] opcode_i,
   input wire logic [7:0] operand_i,
   // decoded fields
   output aal_pkg::aal_decode_type dec_o
);
   import aal_pkg::*;

   logic [3:0] grp;
   logic [3:0] nib;

   assign grp = opcode_i[7:4];
   assign nib = opcode_i[3:0];

   always_comb begin
      dec_o = '0;
      dec_o.byte_op = opcode_i[0];
      dec_o.form = aal_form_type'(nib[3:1]);
      dec_o.short_mode = aal_short_type'(operand_i[3:2]);
      dec_o.imm3 = operand_i[2:0];
      if (nib > FORM_NIB_MAX) begin
         dec_o.valid = 1'b0;
      end else if (grp == GRP_ADD) begin
         dec_o.valid = 1'b1;
         dec_o.op = AAL_OP_ADD;
      end else if (grp == GRP_WORD_SUM_WITH_CARRY_OP) begin
         dec_o.valid = 1'b1;
         dec_o.op = AAL_OP_WORD_SUM_WITH_CARRY_OP;
      end else if (grp == GRP_AND && !opcode_i[0]) begin
         dec_o.valid = 1'b1;
         dec_o.op = AAL_OP_AND;
      end else begin
         dec_o.valid = 1'b0;
      end
      // memory and 16-bit immediate forms are double-word instructions
      if (nib[3:1] == AAL_FORM_RR || nib[3:1] == AAL_FORM_SHORT) begin
         dec_o.length = LEN_SHORT;
      end else begin
         dec_o.length = LEN_LONG;
      end
   end

endmodule

//--- hdl/aal_core.sv
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module aal_core #(
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // avalon-mm slave
   input wire logic [aal_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [aal_pkg::BUS_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [aal_pkg::BUS_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // datapath results
   output logic [15:0] result_o,
   output logic [15:0] processor_status_word_o,
   output logic exec_done_o,
   output logic illegal_o
);
   import aal_pkg::*;

   if (DATA_W != WORD_W) begin : g_bad_width
      $error("aal_core: DATA_W must be 16");
   end

   aal_bus_type bus_state;
   logic [15:0] instr;
   logic [15:0] dst;
   logic [15:0] src;
   logic [15:0] processor_status_word;
   logic [15:0] result;
   logic [1:0] ctrl;
   logic [15:0] exec_count;
   aal_decode_type dec_q;
   aal_decode_type dec_new;
   logic wr_take;
   logic exec_go;
   logic [15:0] src_eff;
   logic cin;
   logic [16:0] word_sum;
   logic [8:0] byte_sum;
   logic [15:0] next_result;
   logic res_msb;
   logic res_zero;
   aal_flags_type next_flags;
   logic [15:0] next_psw;
   logic [31:0] next_readdata;

   // byte-lane merge for the 16-bit registers
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [15:0] v;
      v = old_v;
      for (int i = 0; i < 2; i++) begin
         if (be[i]) begin
            v[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return v;
   endfunction

   // decode of the instruction being written
   aal_decode u_decode (
      .opcode_i(avs_writedata_i[7:0]),
      .operand_i(avs_writedata_i[15:8]),
      .dec_o(dec_new)
   );

   // bus handshake: one wait cycle, then the access completes
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_state <= AAL_BUS_IDLE;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= '0;
      end else begin
         case (bus_state)
            AAL_BUS_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_state <= AAL_BUS_ACK;
                  avs_waitrequest_o <= 1'b0;
                  avs_readdata_o <= avs_read_i ? next_readdata : '0;
               end
            end
            AAL_BUS_ACK: begin
               bus_state <= AAL_BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
            default: begin
               bus_state <= AAL_BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
         endcase
      end
   end

   assign wr_take = (bus_state == AAL_BUS_ACK) && avs_write_i;
   assign exec_go = wr_take && (avs_address_i == OFS_INSTR) && avs_byteenable_i[0] && dec_new.valid;

   // read mux
   always_comb begin
      next_readdata = '0;
      if (avs_address_i == OFS_INSTR) begin
         next_readdata[15:0] = instr;
      end else if (avs_address_i == OFS_DST) begin
         next_readdata[15:0] = dst;
      end else if (avs_address_i == OFS_SRC) begin
         next_readdata[15:0] = src;
      end else if (avs_address_i == OFS_PSW) begin
         next_readdata[15:0] = processor_status_word;
      end else if (avs_address_i == OFS_RESULT) begin
         next_readdata[15:0] = result;
      end else if (avs_address_i == OFS_DECODE) begin
         next_readdata[$bits(aal_decode_type)-1:0] = dec_q;
      end else if (avs_address_i == OFS_CTRL) begin
         next_readdata[1:0] = ctrl;
      end else if (avs_address_i == OFS_COUNT) begin
         next_readdata[15:0] = exec_count;
      end else begin
         next_readdata = '0;
      end
   end

   // source operand: 3-bit immediate comes from the instruction itself
   always_comb begin
      if (dec_new.form == AAL_FORM_SHORT && !dec_new.short_mode[1]) begin
         src_eff = {13'h0000, dec_new.imm3};
      end else begin
         src_eff = src;
      end
   end

   assign cin = (dec_new.op == AAL_OP_WORD_SUM_WITH_CARRY_OP) ? processor_status_word[FLAG_C] : 1'b0;
   assign word_sum = {1'b0, dst} + {1'b0, src_eff} + {16'h0000, cin};
   assign byte_sum = {1'b0, dst[7:0]} + {1'b0, src_eff[7:0]} + {8'h00, cin};

   // result selection
   always_comb begin
      if (dec_new.op == AAL_OP_AND) begin
         next_result = dst & src_eff;
      end else if (dec_new.byte_op) begin
         next_result = {dst[15:8], byte_sum[7:0]};
      end else begin
         next_result = word_sum[15:0];
      end
      res_msb = dec_new.byte_op ? next_result[7] : next_result[15];
      res_zero = dec_new.byte_op ? (next_result[7:0] == 8'h00) : (next_result == 16'h0000);
   end

   // condition flags
   always_comb begin
      next_flags.e = processor_status_word[FLAG_E];
      next_flags.z = processor_status_word[FLAG_Z];
      next_flags.v = processor_status_word[FLAG_V];
      next_flags.c = processor_status_word[FLAG_C];
      next_flags.n = res_msb;
      if (dec_new.op != AAL_OP_AND) begin
         if (dec_new.byte_op) begin
            next_flags.e = (src_eff[7:0] == BYTE_MIN_NEG);
            next_flags.v = (dst[7] == src_eff[7]) && (byte_sum[7] != dst[7]);
            next_flags.c = byte_sum[8];
         end else begin
            next_flags.e = (src_eff == WORD_MIN_NEG);
            next_flags.v = (dst[15] == src_eff[15]) && (word_sum[15] != dst[15]);
            next_flags.c = word_sum[16];
         end
         if (dec_new.op == AAL_OP_WORD_SUM_WITH_CARRY_OP) begin
            next_flags.z = res_zero && processor_status_word[FLAG_Z];
         end else begin
            next_flags.z = res_zero;
         end
      end
   end

   // new status word
   always_comb begin
      next_psw = processor_status_word;
      if (ctrl[CTRL_DEST_PSW]) begin
         if (!dec_new.byte_op) begin
            next_psw = next_result;
         end else if (ctrl[CTRL_PSW_HI]) begin
            next_psw = {next_result[7:0], 8'h00};
         end else begin
            next_psw = {8'h00, next_result[7:0]};
         end
      end else begin
         next_psw[FLAG_N] = next_flags.n;
         next_psw[FLAG_C] = next_flags.c;
         next_psw[FLAG_V] = next_flags.v;
         next_psw[FLAG_Z] = next_flags.z;
         next_psw[FLAG_E] = next_flags.e;
      end
   end

   // status word: software write or instruction update
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         processor_status_word <= PSW_RST;
      end else if (exec_go) begin
         processor_status_word <= next_psw;
      end else if (wr_take && avs_address_i == OFS_PSW) begin
         processor_status_word <= lane_merge(processor_status_word, avs_writedata_i, avs_byteenable_i);
      end
   end

   // destination operand; write-back unless status word is the target
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dst <= OPND_RST;
      end else if (exec_go && !ctrl[CTRL_DEST_PSW]) begin
         dst <= next_result;
      end else if (wr_take && avs_address_i == OFS_DST) begin
         dst <= lane_merge(dst, avs_writedata_i, avs_byteenable_i);
      end
   end

   // source operand, control and instruction registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src <= OPND_RST;
         ctrl <= CTRL_RST;
         instr <= OPND_RST;
      end else if (wr_take) begin
         if (avs_address_i == OFS_SRC) begin
            src <= lane_merge(src, avs_writedata_i, avs_byteenable_i);
         end
         if (avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
            ctrl <= avs_writedata_i[1:0];
         end
         if (avs_address_i == OFS_INSTR) begin
            instr <= lane_merge(instr, avs_writedata_i, avs_byteenable_i);
         end
      end
   end

   // result, decode record, counter and strobes
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result <= OPND_RST;
         dec_q <= '0;
         exec_count <= '0;
         exec_done_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         exec_done_o <= exec_go;
         if (wr_take && avs_address_i == OFS_INSTR && avs_byteenable_i[0]) begin
            dec_q <= dec_new;
            illegal_o <= !dec_new.valid;
         end
         if (exec_go) begin
            result <= next_result;
            exec_count <= exec_count + 16'h0001;
         end
      end
   end

   // registered copies for the core side
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_o <= OPND_RST;
         processor_status_word_o <= PSW_RST;
      end else begin
         result_o <= exec_go ? next_result : result;
         processor_status_word_o <= exec_go ? next_psw : processor_status_word;
      end
   end

endmodule

//--- dv/aal_core_asserts.sv
`timescale 1ns/10ps
module aal_core_asserts (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // register bus
   input wire logic [aal_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_write_i,
   input wire logic [aal_pkg::BUS_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   // results
   input wire logic [15:0] result_o,
   input wire logic [15:0] processor_status_word_o,
   input wire logic exec_done_o,
   input wire logic illegal_o
);
   import aal_pkg::*;
   logic [7:0] opc;
   logic [7:0] opnd;
   logic [15:0] src;
   logic [1:0] ctl;
   logic ia;
   logic lgl;
   logic ad;
   logic rz;
   logic [15:0] sv;
   function automatic logic [15:0] mrg(input logic [15:0] o);
      return {avs_byteenable_i[1] ? avs_writedata_i[15:8] : o[15:8],
         avs_byteenable_i[0] ? avs_writedata_i[7:0] : o[7:0]};
   endfunction
   assign ia = avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_INSTR && avs_byteenable_i[0];
   assign lgl = ((opc[7:4] == GRP_ADD || opc[7:4] == GRP_WORD_SUM_WITH_CARRY_OP) && opc[3:0] <= FORM_NIB_MAX) ||
      (opc[7:4] == GRP_AND && !opc[0] && opc[3:0] <= 4'h8);
   assign ad = exec_done_o && !ctl[CTRL_DEST_PSW] && opc[7:4] != GRP_AND;
   assign rz = opc[0] ? result_o[7:0] == 8'h00 : result_o == 16'h0000;
   // short immediate form replaces the source operand
   assign sv = (opc[3] && !opnd[3]) ? {13'h0000, opnd[2:0]} : src;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {opnd, opc, src, ctl} <= '0;
      end else if (avs_write_i && !avs_waitrequest_o) begin
         if (avs_address_i == OFS_INSTR) begin
            {opnd, opc} <= mrg({opnd, opc});
         end
         if (avs_address_i == OFS_SRC) begin
            src <= mrg(src);
         end
         if (avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
            ctl <= avs_writedata_i[1:0];
         end
      end
   end
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   exec_legal_a:
   assert property (ia |=> exec_done_o == lgl && illegal_o == !lgl) else $error("opcode legality wrong");
   exec_cause_a:
   assert property (exec_done_o |-> $past(ia)) else $error("execution without instruction");
   no_exec_a:
   assert property (ia ##1 illegal_o |-> $stable(result_o) && $stable(processor_status_word_o))
      else $error("refused opcode changed results");
   sign_flag_a:
   assert property (exec_done_o && !ctl[0] |-> processor_status_word_o[FLAG_N] == (opc[0] ? result_o[7] : result_o[15]))
      else $error("sign flag wrong");
   zero_plain_a:
   assert property (ad && opc[7:4] == GRP_ADD |-> processor_status_word_o[FLAG_Z] == rz) else $error("zero flag wrong");
   zero_carry_a:
   assert property (ad && opc[7:4] == GRP_WORD_SUM_WITH_CARRY_OP |-> processor_status_word_o[FLAG_Z] ==
      (rz && $past(processor_status_word_o[FLAG_Z]))) else $error("chained zero flag wrong");
   tab_end_a:
   assert property (ad |-> processor_status_word_o[FLAG_E] == (opc[0] ? sv[7:0] == BYTE_MIN_NEG : sv == WORD_MIN_NEG))
      else $error("table end flag wrong");
   psw_dest_a:
   assert property (exec_done_o && ctl[0] |-> processor_status_word_o == (!opc[0] ? result_o :
      ctl[1] ? {result_o[7:0], 8'h00} : {8'h00, result_o[7:0]})) else $error("status word destination wrong");
endmodule
bind aal_core aal_core_asserts u_asserts (.sys_clk_i, .rst_n_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
   .avs_byteenable_i, .avs_waitrequest_o, .result_o, .processor_status_word_o, .exec_done_o, .illegal_o);

//--- dv/aal_bus_master.sv
`timescale 1ns/10ps
module aal_bus_master (
   // clock
   input wire logic sys_clk_i,
   // slave answer
   input wire logic avs_waitrequest_i,
   input wire logic [aal_pkg::BUS_W-1:0] avs_readdata_i,
   // request
   output logic [aal_pkg::ADDR_W-1:0] avs_address_o,
   output logic avs_read_o,
   output logic avs_write_o,
   output logic [aal_pkg::BUS_W-1:0] avs_writedata_o,
   output logic [3:0] avs_byteenable_o
);
   import aal_pkg::*;
   initial begin
      {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o, avs_byteenable_o} = '0;
   end
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [3:0] b,
      output logic [15:0] q, output logic to);
      int n = 0;
      @(posedge sys_clk_i);
      avs_address_o <= a;
      avs_write_o <= w;
      avs_read_o <= !w;
      avs_writedata_o <= {16'h0000, d};
      avs_byteenable_o <= b;
      to = 1'b1;
      // sampled at the rising edge, before the slave's own update lands
      while (n < 40 && to) begin
         @(posedge sys_clk_i);
         n++;
         to = avs_waitrequest_i;
      end
      q = avs_readdata_i[15:0];
      avs_write_o <= 1'b0;
      avs_read_o <= 1'b0;
      avs_writedata_o <= ~avs_writedata_o;
   endtask
endmodule

//--- dv/aal_core_tb_top.sv
`timescale 1ns/10ps
module aal_core_tb_top;
   import aal_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [ADDR_W-1:0] avs_address_i;
   logic avs_read_i;
   logic avs_write_i;
   logic [BUS_W-1:0] avs_writedata_i;
   logic [3:0] avs_byteenable_i;
   logic [BUS_W-1:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [15:0] result_o;
   logic [15:0] processor_status_word_o;
   logic exec_done_o;
   logic illegal_o;
   int mismatches = 0;
   int compares = 0;
   int n_exec = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   aal_core #(.DATA_W(16)) u_dut (.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .result_o,
      .processor_status_word_o, .exec_done_o, .illegal_o);
   aal_bus_master u_master (.sys_clk_i, .avs_waitrequest_i(avs_waitrequest_o), .avs_readdata_i(avs_readdata_o),
      .avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
      .avs_writedata_o(avs_writedata_i), .avs_byteenable_o(avs_byteenable_i));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [3:0] b,
      output logic [15:0] q);
      logic to;
      u_master.xfer(w, a, d, b, q, to);
      if (to) begin
         mismatches++;
         close_out();
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, 4'h3, q);
   endtask
   // byte operands sit in the top byte so one 16-bit sum yields all flags
   function automatic logic [31:0] model(input logic [7:0] op, input logic [7:0] nd, input logic [15:0] d,
      input logic [15:0] s, input logic [15:0] p);
      logic [15:0] a;
      logic [15:0] b;
      logic [16:0] sum;
      logic cin;
      b = (op[3] && !nd[3]) ? {13'h0000, nd[2:0]} : s;
      if (op[7:4] == GRP_AND) begin
         a = d & b;
         return {p[15:1], a[15], a};
      end
      a = op[0] ? {d[7:0], 8'h00} : d;
      b = op[0] ? {b[7:0], 8'h00} : b;
      cin = op[4] && p[FLAG_C];
      sum = a + b + (op[0] ? {cin, 8'h00} : {8'h00, cin});
      return {p[15:5], b == WORD_MIN_NEG, sum[15:0] == 16'h0000 && (!op[4] || p[FLAG_Z]),
         a[15] == b[15] && sum[15] != a[15], sum[16], sum[15], op[0] ? {8'h00, sum[15:8]} : sum[15:0]};
   endfunction
   task automatic ex(input logic [7:0] op, input logic [7:0] nd, input logic [15:0] d, input logic [15:0] s,
      input logic [15:0] p);
      logic [31:0] e;
      logic [15:0] q;
      e = model(op, nd, d, s, p);
      wr(OFS_DST, d);
      wr(OFS_SRC, s);
      wr(OFS_PSW, p);
      wr(OFS_INSTR, {nd, op});
      @(negedge sys_clk_i);
      n_exec++;
      chk({exec_done_o, illegal_o}, 2'b10);
      chk(result_o & (op[0] ? 16'h00FF : 16'hFFFF), e[15:0]);
      chk(processor_status_word_o, e[31:16]);
      bus(1'b0, OFS_DST, 16'h0000, 4'hF, q);
      chk(q, op[0] ? {d[15:8], e[7:0]} : e[15:0]);
   endtask
   task automatic t_adds();
      logic [15:0] dv [4] = '{16'h7FFF, 16'h8080, 16'hFFFF, 16'h0000};
      logic [15:0] sv [4] = '{16'h0001, 16'h8080, 16'h0000, 16'h8000};
      logic [15:0] pv [4] = '{16'h0000, 16'h000A, 16'h000A, 16'h0002};
      logic [7:0] md [4] = '{8'h05, 8'h0E, 8'h09, 8'hF0};
      logic [15:0] q;
      for (int g = 0; g < 2; g++) begin
         for (int f = 0; f < 10; f++) begin
            for (int k = 0; k < 4; k++) begin
               ex({4'(g), 4'(f)}, md[k], dv[k], sv[k], pv[k]);
            end
            bus(1'b0, OFS_DECODE, 16'h0000, 4'hF, q);
            chk({q[11:9], q[6:0]}, {(f > 1 && f < 8) ? LEN_LONG : LEN_SHORT, 3'(f / 2), 2'(g), 1'(f), 1'b1});
         end
      end
   endtask
   task automatic t_and();
      for (int f = 0; f < 10; f += 2) begin
         ex({GRP_AND, 4'(f)}, 8'h03, 16'hF0F0, 16'h3C3C, 16'h001E);
         ex({GRP_AND, 4'(f)}, 8'h0B, 16'hFFFF, 16'h8001, 16'h0000);
      end
   endtask
   task automatic t_ill();
      logic [7:0] bad [4] = '{8'h0A, 8'h1F, 8'h61, 8'h6A};
      logic [15:0] r;
      for (int k = 0; k < 4; k++) begin
         r = result_o;
         wr(OFS_INSTR, {8'h00, bad[k]});
         @(negedge sys_clk_i);
         chk({exec_done_o, illegal_o, result_o}, {2'b01, r});
      end
   endtask
   task automatic t_pswdst();
      logic [15:0] ev [3] = '{16'h2345, 16'h0045, 16'h4500};
      for (int k = 0; k < 3; k++) begin
         wr(OFS_CTRL, k == 2 ? 16'h0003 : 16'h0001);
         wr(OFS_DST, 16'h1234);
         wr(OFS_SRC, 16'h1111);
         wr(OFS_PSW, 16'hFFFF);
         wr(OFS_INSTR, {15'h0000, k > 0});
         @(negedge sys_clk_i);
         n_exec++;
         chk(processor_status_word_o, ev[k]);
      end
      wr(OFS_CTRL, 16'h0000);
   endtask
   task automatic t_regs();
      logic [15:0] q;
      bus(1'b1, OFS_PSW, 16'hA5C3, 4'h1, q);
      bus(1'b0, OFS_PSW, 16'h0000, 4'hF, q);
      chk(q, 16'h45C3);
      bus(1'b0, OFS_COUNT, 16'h0000, 4'hF, q);
      chk(q, n_exec);
      bus(1'b1, 6'h20, 16'hFFFF, 4'h3, q);
      bus(1'b0, 6'h20, 16'h0000, 4'hF, q);
      chk(q, 16'h0000);
   endtask
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_adds();
      t_and();
      t_ill();
      t_pswdst();
      t_regs();
      close_out();
   end
endmodule
